// *** key_wake_ports.sv ***
// two 8-bit ports with falling-edge key wake-up and an AXI4-Lite slave
// assumes pin inputs synchronous to core_clk; the bench resolves pin wires
//
// What this block does
// - sixteen pins, fifteen wake, G7 only start
// - falling edge on capable pin sets flag
// - interrupt when flag and enable both set
// - all wake sources share one interrupt
// - edges detected for inputs and outputs alike
// - stop wake path has no flip-flops
// - interrupt wakes cpu from stop or wait
// - stop filter rejects short pulses
// - pull select high pulls up, low down
// - direction bit zero input, one output
// - all pins inputs after reset
// - writing one clears a wake flag
// - start detect gates G6 on G7, open-drain
// - port G flag bit 7 reads zero
`timescale 1ns/1ns
module key_wake_ports (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [kwu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [kwu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_g_pins_in,
  input wire logic [7:0] port_h_pins_in,
  input wire logic port_g_pull_select,
  input wire logic port_h_pull_select,
  input wire logic stop_mode,
  output kwu_pkg::pin_drive_s port_g_drive,
  output kwu_pkg::pin_drive_s port_h_drive,
  output logic key_wake_irq
);
  import kwu_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic aw_held;
  logic next_aw_held;
  logic [5:0] aw_index;
  logic [5:0] next_aw_index;
  logic w_held;
  logic next_w_held;
  logic [7:0] w_byte;
  logic [7:0] next_w_byte;
  logic w_lane;
  logic next_w_lane;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  logic [7:0] data_g;
  logic [7:0] next_data_g;
  logic [7:0] data_h;
  logic [7:0] next_data_h;
  logic [7:0] dir_g;
  logic [7:0] next_dir_g;
  logic [7:0] dir_h;
  logic [7:0] next_dir_h;
  logic [7:0] en_g;
  logic [7:0] next_en_g;
  logic [7:0] en_h;
  logic [7:0] next_en_h;

  logic [7:0] flags_g;
  logic [7:0] next_flags_g;
  logic [7:0] flags_h;
  logic [7:0] next_flags_h;
  logic [7:0] pend_g;
  logic [7:0] next_pend_g;
  logic [7:0] pend_h;
  logic [7:0] next_pend_h;
  logic [7:0] prev_g;
  logic [7:0] prev_h;

  logic wr_fire;
  logic ar_fire;
  logic [5:0] ar_index;
  logic i2c_sel;
  logic [7:0] wake_en_g;
  logic [7:0] fall_g;
  logic [7:0] fall_h;
  logic [7:0] clr_g;
  logic [7:0] clr_h;
  logic stop_wake;
  logic filter_accept;
  logic filter_reject;

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign ar_fire = s_axi_arvalid && !rvalid;
  assign ar_index = s_axi_araddr[ADDR_W-1:2];

  // address and data are held until both are in, then answered
  always_comb begin
    next_aw_held = aw_held;
    next_aw_index = aw_index;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_index = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_index >= IDX_PORT_G_DATA && aw_index <= IDX_PORT_H_WAKE_FLAGS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (ar_index)
        IDX_PORT_G_DATA: next_rdata[7:0] = (dir_g & data_g) | (~dir_g & port_g_pins_in);
        IDX_PORT_H_DATA: next_rdata[7:0] = (dir_h & data_h) | (~dir_h & port_h_pins_in);
        IDX_PORT_G_DIRECTION: next_rdata[7:0] = dir_g;
        IDX_PORT_H_DIRECTION: next_rdata[7:0] = dir_h;
        IDX_PORT_G_WAKE_ENABLES: next_rdata[7:0] = en_g;
        IDX_PORT_H_WAKE_ENABLES: next_rdata[7:0] = en_h;
        IDX_PORT_G_WAKE_FLAGS: next_rdata[7:0] = flags_g & PORT_G_WAKE_CAPABLE;
        IDX_PORT_H_WAKE_FLAGS: next_rdata[7:0] = flags_h;
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_index <= 6'h00;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      aw_index <= next_aw_index;
      w_held <= next_w_held;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_comb begin
    next_data_g = data_g;
    next_data_h = data_h;
    next_dir_g = dir_g;
    next_dir_h = dir_h;
    next_en_g = en_g;
    next_en_h = en_h;
    if (wr_fire && w_lane) begin
      case (aw_index)
        IDX_PORT_G_DATA: next_data_g = w_byte;
        IDX_PORT_H_DATA: next_data_h = w_byte;
        IDX_PORT_G_DIRECTION: next_dir_g = w_byte;
        IDX_PORT_H_DIRECTION: next_dir_h = w_byte;
        IDX_PORT_G_WAKE_ENABLES: next_en_g = w_byte;
        IDX_PORT_H_WAKE_ENABLES: next_en_h = w_byte;
        default: next_en_h = en_h;
      endcase
    end
  end

  // all pins come out of reset as inputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_g <= DATA_RESET;
      data_h <= DATA_RESET;
      dir_g <= DIRECTION_RESET;
      dir_h <= DIRECTION_RESET;
      en_g <= ENABLES_RESET;
      en_h <= ENABLES_RESET;
    end else begin
      data_g <= next_data_g;
      data_h <= next_data_h;
      dir_g <= next_dir_g;
      dir_h <= next_dir_h;
      en_g <= next_en_g;
      en_h <= next_en_h;
    end
  end

  // ---------------------------------------------------------------
  // pin drive: push-pull, or open-drain on G6/G7 in start mode
  // ---------------------------------------------------------------
  assign i2c_sel = en_g[I2C_SELECT_BIT];
  assign port_g_drive.pull_up_en = port_g_pull_select;
  assign port_g_drive.pull_down_en = !port_g_pull_select;
  assign port_h_drive.pull_up_en = port_h_pull_select;
  assign port_h_drive.pull_down_en = !port_h_pull_select;

  for (genvar b = 0; b < 8; b++) begin : g_pin
    localparam bit OD_PIN = (b == SDA_BIT) || (b == SCL_BIT);
    always_comb begin
      if (OD_PIN && i2c_sel) begin
        port_g_drive.out[b] = 1'b0;
        port_g_drive.oe[b] = dir_g[b] && !data_g[b];
      end else begin
        port_g_drive.out[b] = data_g[b];
        port_g_drive.oe[b] = dir_g[b];
      end
      port_h_drive.out[b] = data_h[b];
      port_h_drive.oe[b] = dir_h[b];
    end
  end

  // ---------------------------------------------------------------
  // edge detection and wake flags
  // ---------------------------------------------------------------
  // pin levels read regardless of direction
  assign fall_h = prev_h & ~port_h_pins_in;
  always_comb begin
    fall_g = prev_g & ~port_g_pins_in & PORT_G_WAKE_CAPABLE;
    if (i2c_sel && !(prev_g[SCL_BIT] && port_g_pins_in[SCL_BIT])) begin
      fall_g[SDA_BIT] = 1'b0;
    end
  end

  assign wake_en_g = en_g & PORT_G_WAKE_CAPABLE;
  assign clr_g = (wr_fire && w_lane && aw_index == IDX_PORT_G_WAKE_FLAGS) ? w_byte : 8'h00;
  assign clr_h = (wr_fire && w_lane && aw_index == IDX_PORT_H_WAKE_FLAGS) ? w_byte : 8'h00;

  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_flags_g = flags_g & ~clr_g;
    next_flags_h = flags_h & ~clr_h;
    next_pend_g = pend_g;
    next_pend_h = pend_h;
    if (stop_mode) begin
      if (filter_accept) begin
        next_flags_g = next_flags_g | (pend_g & wake_en_g);
        next_flags_h = next_flags_h | (pend_h & en_h);
      end
      if (filter_accept || filter_reject) begin
        next_pend_g = 8'h00;
        next_pend_h = 8'h00;
      end
      next_pend_g = next_pend_g | (fall_g & wake_en_g);
      next_pend_h = next_pend_h | (fall_h & en_h);
    end else begin
      next_flags_g = next_flags_g | fall_g;
      next_flags_h = next_flags_h | fall_h;
      next_pend_g = 8'h00;
      next_pend_h = 8'h00;
    end
    next_flags_g = next_flags_g & PORT_G_WAKE_CAPABLE;
  end

  // flag, pending and previous-level registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_g <= FLAGS_RESET;
      flags_h <= FLAGS_RESET;
      pend_g <= FLAGS_RESET;
      pend_h <= FLAGS_RESET;
      prev_g <= 8'h00;
      prev_h <= 8'h00;
    end else begin
      flags_g <= next_flags_g;
      flags_h <= next_flags_h;
      pend_g <= next_pend_g;
      pend_h <= next_pend_h;
      prev_g <= port_g_pins_in;
      prev_h <= port_h_pins_in;
    end
  end

  // ---------------------------------------------------------------
  // stop filter and interrupt
  // ---------------------------------------------------------------
  key_wake_filter u_filter (
    .core_clk(core_clk),
    .rstn(rstn),
    .stop_mode(stop_mode),
    .trigger(|({fall_h & en_h, fall_g & wake_en_g})),
    .level_active(|({~port_h_pins_in & en_h, ~port_g_pins_in & wake_en_g})),
    .accept(filter_accept),
    .reject(filter_reject)
  );

  // gate-only path from an enabled low pin while stopped
  assign stop_wake = stop_mode && |({~port_h_pins_in & en_h, ~port_g_pins_in & wake_en_g});
  // one request for all fifteen sources, for stop or wait
  assign key_wake_irq = |({flags_h & en_h, flags_g & wake_en_g}) || stop_wake;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_irq_level;
    (|(flags_h & en_h)) || (|(flags_g & en_g & PORT_G_WAKE_CAPABLE)) |-> key_wake_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq low with pending flag");

  property p_g7_zero;
    ##1 !flags_g[SCL_BIT] && !(rvalid && $past(ar_fire) && $past(ar_index) == IDX_PORT_G_WAKE_FLAGS && rdata[7]);
  endproperty
  a_g7_zero: assert property (p_g7_zero) else $error("port G flag 7 set");

  property p_edge_sets;
    !stop_mode && prev_h[0] && !port_h_pins_in[0] |=> flags_h[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("falling edge not flagged");

  property p_w1c;
    wr_fire && w_lane && aw_index == IDX_PORT_H_WAKE_FLAGS && w_byte[0] && !fall_h[0] |=> !flags_h[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by write one");

  property p_dir_reset;
    $rose(rstn) |-> dir_g == DIRECTION_RESET && dir_h == DIRECTION_RESET;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir not cleared");

  property p_dir_drive;
    wr_fire && w_lane && aw_index == IDX_PORT_H_DIRECTION |=> port_h_drive.oe == $past(w_byte);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("direction not on pins");

  property p_stop_path;
    stop_mode && en_h[0] && !port_h_pins_in[0] |-> key_wake_irq;
  endproperty
  a_stop_path: assert property (p_stop_path) else $error("stop wake path missing");

  property p_i2c_gate;
    !stop_mode && i2c_sel && !port_g_pins_in[SCL_BIT] && !flags_g[SDA_BIT] |=> !flags_g[SDA_BIT];
  endproperty
  a_i2c_gate: assert property (p_i2c_gate) else $error("G6 flagged without G7 high");

  property p_read_port;
    ar_fire && ar_index == IDX_PORT_G_DATA
      |=> rdata[7:0] == (($past(dir_g) & $past(data_g)) | (~$past(dir_g) & $past(port_g_pins_in)));
  endproperty
  a_read_port: assert property (p_read_port) else $error("port read mismatch");

endmodule

// *** kwu_pkg.sv ***
// constants, types and register map shared by the key wake-up port block
// assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus
package kwu_pkg;

  // ---------------------------------------------------------------
  // register map: indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_PORT_G_DATA = 6'h28;
  localparam logic [5:0] IDX_PORT_H_DATA = 6'h29;
  localparam logic [5:0] IDX_PORT_G_DIRECTION = 6'h2A;
  localparam logic [5:0] IDX_PORT_H_DIRECTION = 6'h2B;
  localparam logic [5:0] IDX_PORT_G_WAKE_ENABLES = 6'h2C;
  localparam logic [5:0] IDX_PORT_H_WAKE_ENABLES = 6'h2D;
  localparam logic [5:0] IDX_PORT_G_WAKE_FLAGS = 6'h2E;
  localparam logic [5:0] IDX_PORT_H_WAKE_FLAGS = 6'h2F;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PORT_G_WAKE_CAPABLE = 8'h7F;
  localparam logic [7:0] PORT_H_WAKE_CAPABLE = 8'hFF;
  localparam int unsigned I2C_SELECT_BIT = 7;
  localparam int unsigned SDA_BIT = 6;
  localparam int unsigned SCL_BIT = 7;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // stop filter timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned FILTER_SAMPLE_NS = 100;
  localparam int unsigned FILTER_TICK_CYCLES = (FILTER_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] VOTE_SAMPLES = 2'h3;
  localparam logic [1:0] VOTE_MAJORITY = 2'h2;

  // pin drive and pull control of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic pull_up_en;
    logic pull_down_en;
  } pin_drive_s;

  // stop filter states
  typedef enum logic [2:0] {
    F_IDLE = 3'b001,
    F_SAMPLE = 3'b010,
    F_DONE = 3'b100
  } filter_state_e;

endpackage

// *** key_wake_filter.sv ***
// majority vote filter for wake-up pulses while in stop
// assumes trigger and level come from the port block on the same clock
`timescale 1ns/1ns
module key_wake_filter (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic stop_mode,
  input wire logic trigger,
  input wire logic level_active,
  output logic accept,
  output logic reject
);
  import kwu_pkg::*;

  localparam int VOTE_BOUND = 60;

  filter_state_e state;
  filter_state_e next_state;
  logic [7:0] tick;
  logic [7:0] next_tick;
  logic [1:0] taken;
  logic [1:0] next_taken;
  logic [1:0] hits;
  logic [1:0] next_hits;

  // ---------------------------------------------------------------
  // three samples spaced one tick apart, two low ones pass
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_tick = tick;
    next_taken = taken;
    next_hits = hits;
    case (state)
      F_IDLE: begin
        next_tick = 8'h00;
        next_taken = 2'h0;
        next_hits = 2'h0;
        if (stop_mode && trigger) begin
          next_state = F_SAMPLE;
        end
      end
      F_SAMPLE: begin
        if (!stop_mode) begin
          next_state = F_IDLE;
        end else if (tick == 8'(FILTER_TICK_CYCLES - 1)) begin
          next_tick = 8'h00;
          next_taken = taken + 2'h1;
          next_hits = hits + {1'b0, level_active};
          if (taken + 2'h1 == VOTE_SAMPLES) begin
            next_state = F_DONE;
          end
        end else begin
          next_tick = tick + 8'h01;
        end
      end
      F_DONE: next_state = F_IDLE;
      default: next_state = F_IDLE;
    endcase
  end

  // filter registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= F_IDLE;
      tick <= 8'h00;
      taken <= 2'h0;
      hits <= 2'h0;
    end else begin
      state <= next_state;
      tick <= next_tick;
      taken <= next_taken;
      hits <= next_hits;
    end
  end

  // verdict pulses in the done state
  assign accept = (state == F_DONE) && (hits >= VOTE_MAJORITY);
  assign reject = (state == F_DONE) && (hits < VOTE_MAJORITY);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_filter_start;
    (state == F_IDLE) && stop_mode && trigger;
  endsequence

  sequence s_filter_verdict;
    accept || reject || !stop_mode;
  endsequence

  property p_filter_ends;
    @(posedge core_clk) disable iff (!rstn)
    s_filter_start |-> ##[1:VOTE_BOUND] s_filter_verdict;
  endproperty
  a_filter_ends: assert property (p_filter_ends) else $error("stop filter gave no verdict");

  property p_verdict_exclusive;
    @(posedge core_clk) disable iff (!rstn)
    accept |-> !reject && hits >= VOTE_MAJORITY && $past(state) == F_SAMPLE;
  endproperty
  a_verdict_exclusive: assert property (p_verdict_exclusive) else $error("bad filter verdict");

endmodule

// *** key_pin_model.sv ***
// far-side model of one port: switches to ground plus the pull resistors
// assumes the drive struct of the port block; a pressed key pulls the pin low
`timescale 1ns/1ns
module key_pin_model (
  input kwu_pkg::pin_drive_s drive,
  input wire logic [7:0] key_low,
  output logic [7:0] pins
);
  import kwu_pkg::*;
  // ----------------------------------------
  // wire resolution per pin
  // ----------------------------------------
  // driven pin shows latch, else key or pull level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drive.oe[i]) begin
        pins[i] = drive.out[i];
      end else if (key_low[i]) begin
        pins[i] = 1'b0;
      end else begin
        pins[i] = drive.pull_up_en;
      end
    end
  end
endmodule

// *** key_wakeup_gpio_ports_tb.sv ***
// self-checking bench for the key wake-up port block
// assumes kwu_pkg, key_wake_ports and key_pin_model compiled before it
`timescale 1ns/1ns
module key_wakeup_gpio_ports_tb;
  import kwu_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, key_wake_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] key_g = 8'h00, key_h = 8'h00, pins_g, pins_h;
  logic pull_g = 1'b1, pull_h = 1'b1, stop_mode = 1'b0;
  pin_drive_s drive_g, drive_h;
  logic [7:0] rd_val;
  logic [1:0] rsp;
  int num_errors = 0;
  int compares = 0;
  // ----------------------------------------
  // clock, design and pin models
  // ----------------------------------------
  always #4 core_clk = ~core_clk;
  key_wake_ports uut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_g_pins_in(pins_g),
    .port_h_pins_in(pins_h), .port_g_pull_select(pull_g), .port_h_pull_select(pull_h),
    .stop_mode(stop_mode), .port_g_drive(drive_g), .port_h_drive(drive_h), .key_wake_irq(key_wake_irq));
  key_pin_model g_side (.drive(drive_g), .key_low(key_g), .pins(pins_g));
  key_pin_model h_side (.drive(drive_h), .key_low(key_h), .pins(pins_h));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  // write one register, each channel released when taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  // read one register
  task automatic rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    rd(idx, rd_val, rsp);
    chk(rd_val, exp);
    chk({6'h0, rsp}, {6'h0, RESP_OKAY});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(IDX_PORT_G_DIRECTION, 8'h00);
    rdchk(IDX_PORT_H_DIRECTION, 8'h00);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h00);
    chk(drive_g.oe | drive_h.oe, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_direction;
    wr(IDX_PORT_G_DIRECTION, 8'h0F, rsp);
    chk({6'h0, rsp}, {6'h0, RESP_OKAY});
    wr(IDX_PORT_G_DATA, 8'hA5, rsp);
    chk(drive_g.oe, 8'h0F);
    chk({4'h0, drive_g.out[3:0]}, 8'h05);
    rdchk(IDX_PORT_G_DATA, 8'hF5);
    chk({6'h0, drive_g.pull_up_en, drive_g.pull_down_en}, 8'h02);
    pull_g <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    chk({6'h0, drive_g.pull_up_en, drive_g.pull_down_en}, 8'h01);
    rdchk(IDX_PORT_G_DATA, 8'h05);
    pull_g <= 1'b1;
    $display("test direction done");
  endtask
  task automatic t_wake;
    wr(IDX_PORT_H_WAKE_ENABLES, 8'h01, rsp);
    key_h <= 8'h01;
    repeat (3) @(posedge core_clk);
    chk({7'h0, key_wake_irq}, 8'h01);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h01);
    wr(IDX_PORT_H_WAKE_FLAGS, 8'h00, rsp);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h01);
    key_h <= 8'h00;
    wr(IDX_PORT_H_WAKE_FLAGS, 8'h01, rsp);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h00);
    chk({7'h0, key_wake_irq}, 8'h00);
    $display("test wake done");
  endtask
  task automatic t_output_edge;
    wr(IDX_PORT_H_DIRECTION, 8'h04, rsp);
    wr(IDX_PORT_H_DATA, 8'h04, rsp);
    chk(drive_h.out, 8'h04);
    chk({6'h0, drive_h.pull_up_en, drive_h.pull_down_en}, 8'h02);
    wr(IDX_PORT_H_DATA, 8'h00, rsp);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h04);
    chk({7'h0, key_wake_irq}, 8'h00);
    wr(IDX_PORT_H_WAKE_ENABLES, 8'h05, rsp);
    chk({7'h0, key_wake_irq}, 8'h01);
    wr(IDX_PORT_H_WAKE_FLAGS, 8'h04, rsp);
    wr(IDX_PORT_H_WAKE_ENABLES, 8'h01, rsp);
    $display("test output edge done");
  endtask
  task automatic t_bit7;
    wr(IDX_PORT_G_WAKE_FLAGS, 8'hFF, rsp);
    key_g <= 8'h80;
    repeat (3) @(posedge core_clk);
    key_g <= 8'h00;
    rdchk(IDX_PORT_G_WAKE_FLAGS, 8'h00);
    rd(6'h00, rd_val, rsp);
    chk({6'h0, rsp}, {6'h0, RESP_SLVERR});
    $display("test bit7 done");
  endtask
  // start detect: G6 edge counts only while G7 stays high, G6/G7 open-drain
  task automatic t_i2c;
    wr(IDX_PORT_G_WAKE_ENABLES, 8'h80, rsp);
    chk({6'h0, drive_g.out[7:6]}, 8'h00);
    key_g <= 8'h80;
    repeat (2) @(posedge core_clk);
    key_g <= 8'hC0;
    repeat (2) @(posedge core_clk);
    key_g <= 8'h00;
    repeat (2) @(posedge core_clk);
    rdchk(IDX_PORT_G_WAKE_FLAGS, 8'h00);
    key_g <= 8'h40;
    repeat (2) @(posedge core_clk);
    key_g <= 8'h00;
    rdchk(IDX_PORT_G_WAKE_FLAGS, 8'h40);
    wr(IDX_PORT_G_WAKE_FLAGS, 8'h40, rsp);
    wr(IDX_PORT_G_WAKE_ENABLES, 8'h00, rsp);
    $display("test i2c start done");
  endtask
  task automatic t_stop;
    stop_mode <= 1'b1;
    @(posedge core_clk);
    key_h <= 8'h01;
    @(posedge core_clk);
    @(negedge core_clk);
    chk({7'h0, key_wake_irq}, 8'h01);
    repeat (4) @(posedge core_clk);
    key_h <= 8'h00;
    repeat (80) @(posedge core_clk);
    chk({7'h0, key_wake_irq}, 8'h00);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h00);
    key_h <= 8'h01;
    repeat (80) @(posedge core_clk);
    rdchk(IDX_PORT_H_WAKE_FLAGS, 8'h01);
    key_h <= 8'h00;
    stop_mode <= 1'b0;
    $display("test stop done");
  endtask
  // ----------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic final_report;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_direction();
    t_wake();
    t_output_edge();
    t_bit7();
    t_i2c();
    t_stop();
    final_report();
  end
endmodule
